// File: design/hpi_defs.vh
// Constants for the host port interface block.
`ifndef HPI_DEFS_VH
`define HPI_DEFS_VH
`define HPI_CTL_BYTE_ORDER    0
`define HPI_CTL_CORE_IRQ      1
`define HPI_CTL_HOST_IRQ      2
`define HPI_CTL_WIDTH         3
`define HPI_CTL_RESET         3'h0
`define HPI_ADDR_W            16
`define HPI_DATA_W            16
`define HPI_BYTE_W            8
`define HPI_ACCESS_DATA_AUTO  2'h1
`define HPI_ACCESS_ADDR       2'h2
`define HPI_ACCESS_CTL        2'h0
`define HPI_ACCESS_DATA       2'h3
`endif

// File: design/hpi_port.v
// Host port interface: host access to on-chip RAM through the DMA bus.
// Summary of operation
// - Slave only; host reaches whole on-chip RAM, never external memory.
// - On contention for one location the host wins; core waits one port cycle.
// - All host accesses are synchronised to the core clock, which must run.
// - Byte mode moves each word as two bytes, byte-half select marks which.
// - Byte mode uses address, data, control registers; core sees control only.
// - Sequential transfers auto-increment the address; random access also works.
// - Byte mode passes interrupts host to core and core to host.
// - Host transfers continue while the core is halted by emulation stop.
// - Wide mode bit set: host uses 16-bit address and data pins.
// - Wide mode frees the eight byte-wide data pins for general I/O.
// - Wide mode port stalls the host by holding ready low.
// - Wide mode every host read or write starts a DMA access.
// - Wide mode DMA address comes from address pins; no auto-increment.
// - Wide write address latched at access end, rising edge of strobe XNOR; read address at access start.
// - Wide mode has only the data read/write access type.
// - Wide mode host cannot reach control register; no polling, no extended bit.
// - Wide mode has no data prefetch.
// - Wide mode passes no interrupts either way.
// - In idle levels one and two, clocks run only for each access.
`timescale 1ns/1ps
`include "hpi_defs.vh"
module hpi_port #(
    parameter AW = `HPI_ADDR_W,
    parameter DW = `HPI_DATA_W,
    parameter BW = `HPI_BYTE_W
) (
    // Clock and reset.
    input  wire          clk_in,
    input  wire          resetn_in,
    // Mode and core side.
    input  wire          wide_nonmux_mode_bit_in,
    input  wire          idle_level_one_in,
    input  wire          idle_level_two_in,
    input  wire          emu_stop_in,
    input  wire          core_irq_host_in,
    input  wire          core_irq_ack_in,
    output reg           host_irq_core_out,
    output reg           access_clk_en_out,
    // Host control pins.
    input  wire          host_chip_select_n_in,
    input  wire          host_data_strobe_one_n_in,
    input  wire          host_data_strobe_two_n_in,
    input  wire          host_read_write_in,
    input  wire          byte_half_select_in,
    input  wire [1:0]    access_type_select_in,
    output reg           host_ready_output_out,
    output reg           host_int_n_out,
    // Byte-wide data bus.
    input  wire [BW-1:0] host_data_bus_in,
    output reg  [BW-1:0] host_data_bus_out,
    output reg           host_data_bus_oe_out,
    // General I/O use of the byte bus in wide mode.
    input  wire [BW-1:0] gpio_out_value_in,
    input  wire [BW-1:0] gpio_dir_in,
    output reg  [BW-1:0] gpio_in_value_out,
    // Wide host address and data buses.
    input  wire [AW-1:0] host_address_bus_in,
    input  wire [DW-1:0] wide_data_in,
    output reg  [DW-1:0] wide_data_out,
    output reg           wide_data_oe_out,
    // Internal DMA bus.
    output reg           dma_req_out,
    output reg           dma_write_out,
    output reg  [AW-1:0] dma_addr_out,
    output reg  [DW-1:0] dma_wdata_out,
    input  wire          dma_ack_in,
    input  wire [DW-1:0] dma_rdata_in,
    // Core access hold-off on contention.
    input  wire          core_req_in,
    input  wire [AW-1:0] core_addr_in,
    output reg           core_hold_out
);
    localparam ST_IDLE = 3'b001;
    localparam ST_DMA  = 3'b010;
    localparam ST_DONE = 3'b100;

    reg  [2:0]    state_reg;
    reg           strobe_d_reg;
    reg  [AW-1:0] host_address_register_reg;
    reg  [DW-1:0] host_data_register_reg;
    reg  [`HPI_CTL_WIDTH-1:0] host_control_register_reg;
    reg  [BW-1:0] low_byte_reg;
    reg           pend_write_reg;
    reg           auto_inc_reg;

    // Internal strobe is low while an access is active.
    wire strobe_n = ~(host_data_strobe_one_n_in ^ host_data_strobe_two_n_in);
    wire active   = ~host_chip_select_n_in & ~strobe_n;
    wire start    = active & ~strobe_d_reg;
    wire ending   = ~active & strobe_d_reg;
    wire wide     = wide_nonmux_mode_bit_in;
    wire data_acc = wide | access_type_select_in[0];
    wire lo_first = host_control_register_reg[`HPI_CTL_BYTE_ORDER];
    wire second   = byte_half_select_in;
    reg  [BW-1:0] byte_rd;

    // Byte-mode read data: the byte that the current half selects.
    always @* begin
        if (second ^ lo_first) begin
            byte_rd = host_data_register_reg[BW-1:0];
        end else begin
            byte_rd = host_data_register_reg[DW-1:BW];
        end
    end

    always @(posedge clk_in) begin
        if (!resetn_in) begin
            strobe_d_reg <= 1'b0;
        end else begin
            strobe_d_reg <= active;
        end
    end

    always @(posedge clk_in) begin
        if (!resetn_in) begin
            host_int_n_out <= 1'b1;
        end else begin
            host_int_n_out <= ~(host_control_register_reg[`HPI_CTL_HOST_IRQ] & ~wide);
        end
    end

    always @(posedge clk_in) begin
        if (!resetn_in) begin
            host_irq_core_out <= 1'b0;
        end else begin
            host_irq_core_out <= host_control_register_reg[`HPI_CTL_CORE_IRQ] & ~wide;
        end
    end

    // Byte bus as general I/O in wide mode.
    always @(posedge clk_in) begin
        if (!resetn_in) begin
            gpio_in_value_out <= {BW{1'b0}};
        end else begin
            gpio_in_value_out <= wide ? host_data_bus_in : {BW{1'b0}};
        end
    end

    always @(posedge clk_in) begin
        if (!resetn_in) begin
            host_data_bus_oe_out <= 1'b0;
        end else begin
            host_data_bus_oe_out <= wide ? |gpio_dir_in :
                                    (active & host_read_write_in);
        end
    end

    always @(posedge clk_in) begin
        if (!resetn_in) begin
            host_data_bus_out <= {BW{1'b0}};
        end else begin
            host_data_bus_out <= wide ? (gpio_out_value_in & gpio_dir_in) : byte_rd;
        end
    end

    always @(posedge clk_in) begin
        if (!resetn_in) begin
            wide_data_oe_out <= 1'b0;
        end else begin
            wide_data_oe_out <= wide & active & host_read_write_in;
        end
    end

    // Host priority: stall a core access to the DMA address for one cycle.
    always @(posedge clk_in) begin
        if (!resetn_in) begin
            core_hold_out <= 1'b0;
        end else begin
            core_hold_out <= core_req_in && dma_req_out && (core_addr_in == dma_addr_out);
        end
    end

    // Clocks run only while an access is in flight in idle.
    always @(posedge clk_in) begin
        if (!resetn_in) begin
            access_clk_en_out <= 1'b0;
        end else begin
            access_clk_en_out <= ~(idle_level_one_in | idle_level_two_in) |
                                 active | (state_reg != ST_IDLE);
        end
    end

    always @(posedge clk_in) begin
        if (!resetn_in) begin
            state_reg                 <= ST_IDLE;
            host_address_register_reg <= {AW{1'b0}};
            host_data_register_reg    <= {DW{1'b0}};
            host_control_register_reg <= `HPI_CTL_RESET;
            low_byte_reg              <= {BW{1'b0}};
            pend_write_reg            <= 1'b0;
            auto_inc_reg              <= 1'b0;
            host_ready_output_out     <= 1'b1;
            wide_data_out             <= {DW{1'b0}};
            dma_req_out               <= 1'b0;
            dma_write_out             <= 1'b0;
            dma_addr_out              <= {AW{1'b0}};
            dma_wdata_out             <= {DW{1'b0}};
        end else begin
            // Core-side control bits; emulation stop has no effect here.
            if (core_irq_host_in && !wide) begin
                host_control_register_reg[`HPI_CTL_HOST_IRQ] <= 1'b1;
            end
            if (core_irq_ack_in && !(start && !wide && !host_read_write_in &&
                access_type_select_in == `HPI_ACCESS_CTL)) begin
                host_control_register_reg[`HPI_CTL_CORE_IRQ] <= 1'b0;
            end
            // Wide mode keeps both interrupt flags clear.
            if (wide)
                host_control_register_reg[`HPI_CTL_HOST_IRQ:`HPI_CTL_CORE_IRQ] <= 2'h0;
            case (state_reg)
                ST_IDLE: begin
                    if (start && wide) begin
                        host_ready_output_out <= 1'b0;
                        if (host_read_write_in) begin
                            dma_req_out   <= 1'b1;
                            dma_write_out <= 1'b0;
                            dma_addr_out  <= host_address_bus_in;
                            state_reg     <= ST_DMA;
                        end
                    end else if (ending && wide && !host_read_write_in) begin
                        // Address and data captured as the strobe rises.
                        // Wide writes go straight to memory with no prefetch.
                        dma_req_out           <= 1'b1;
                        dma_write_out         <= 1'b1;
                        dma_addr_out          <= host_address_bus_in;
                        dma_wdata_out         <= wide_data_in;
                        host_ready_output_out <= 1'b0;
                        state_reg             <= ST_DMA;
                    end else if (start && !wide) begin
                        // Registers answer the host only in byte mode.
                        if (host_read_write_in) begin
                            if (data_acc && (second ^ lo_first)) begin
                                auto_inc_reg <= (access_type_select_in == `HPI_ACCESS_DATA_AUTO);
                            end
                        end else begin
                            case (access_type_select_in)
                                `HPI_ACCESS_CTL:
                                    host_control_register_reg <= {
                                        core_irq_host_in & !wide,
                                        host_data_bus_in[`HPI_CTL_CORE_IRQ] |
                                        host_control_register_reg[`HPI_CTL_CORE_IRQ],
                                        host_data_bus_in[`HPI_CTL_BYTE_ORDER]};
                                `HPI_ACCESS_ADDR:
                                    if (second ^ lo_first)
                                        host_address_register_reg[BW-1:0] <= host_data_bus_in;
                                    else
                                        host_address_register_reg[AW-1:BW] <= host_data_bus_in;
                                default:
                                    if (!(second ^ lo_first)) begin
                                        low_byte_reg <= host_data_bus_in;
                                    end else begin
                                        pend_write_reg <= 1'b1;
                                        auto_inc_reg   <= (access_type_select_in ==
                                                           `HPI_ACCESS_DATA_AUTO);
                                        host_data_register_reg <= {low_byte_reg,
                                                                   host_data_bus_in};
                                    end
                            endcase
                        end
                    end else if (ending && !wide && (pend_write_reg || auto_inc_reg ||
                                 (data_acc && host_read_write_in && (second ^ lo_first)))) begin
                        // Second byte done: write, or fetch the next word.
                        dma_req_out    <= 1'b1;
                        dma_write_out  <= pend_write_reg;
                        dma_wdata_out  <= host_data_register_reg;
                        if (auto_inc_reg && !pend_write_reg)
                            host_address_register_reg <= host_address_register_reg +
                                                         {{(AW-1){1'b0}}, 1'b1};
                        dma_addr_out   <= (auto_inc_reg && !pend_write_reg) ?
                                          host_address_register_reg + {{(AW-1){1'b0}}, 1'b1} :
                                          host_address_register_reg;
                        host_ready_output_out <= 1'b0;
                        state_reg      <= ST_DMA;
                    end
                end
                ST_DMA: begin
                    if (dma_ack_in) begin
                        dma_req_out <= 1'b0;
                        if (!dma_write_out) begin
                            host_data_register_reg <= dma_rdata_in;
                            wide_data_out          <= dma_rdata_in;
                        end else if (!wide && auto_inc_reg) begin
                            host_address_register_reg <= host_address_register_reg +
                                                         {{(AW-1){1'b0}}, 1'b1};
                        end
                        pend_write_reg <= 1'b0;
                        auto_inc_reg   <= 1'b0;
                        state_reg      <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    host_ready_output_out <= 1'b1;
                    state_reg             <= ST_IDLE;
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end
endmodule

// File: testbench/hpi_port_props.sv
// Checker for the host port handshake, address path and interrupt quietness.
`timescale 1ns/1ps
module hpi_port_props (
    input wire        clk_in,
    input wire        resetn_in,
    input wire        wide_nonmux_mode_bit_in,
    input wire        core_req_in,
    input wire [15:0] core_addr_in,
    input wire [15:0] host_address_bus_in,
    input wire        dma_ack_in,
    input wire        dma_req_out,
    input wire [15:0] dma_addr_out,
    input wire        host_ready_output_out,
    input wire        host_int_n_out,
    input wire        host_irq_core_out,
    input wire        host_data_bus_oe_out,
    input wire        core_hold_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    a_req_holds: assert property (dma_req_out && !dma_ack_in |=> dma_req_out)
        else $error("dma request dropped before ack");
    a_ready_stall: assert property (dma_req_out |-> !host_ready_output_out)
        else $error("ready high while dma pending");
    a_ready_back: assert property (dma_req_out && dma_ack_in |=> !dma_req_out ##1 host_ready_output_out)
        else $error("ready not back two cycles after ack");
    a_wide_addr: assert property (wide_nonmux_mode_bit_in && $rose(dma_req_out)
        |-> dma_addr_out == $past(host_address_bus_in))
        else $error("dma address differs from host address");
    a_int_quiet: assert property (wide_nonmux_mode_bit_in && host_int_n_out |=> host_int_n_out)
        else $error("host interrupt in wide mode");
    a_irq_quiet: assert property (wide_nonmux_mode_bit_in && !host_irq_core_out |=> !host_irq_core_out)
        else $error("core interrupt in wide mode");
    a_pins_free: assert property (wide_nonmux_mode_bit_in && $past(wide_nonmux_mode_bit_in)
        |-> !host_data_bus_oe_out)
        else $error("byte bus driven in wide mode");
    a_host_wins: assert property (core_req_in && dma_req_out && core_addr_in == dma_addr_out
        |=> core_hold_out)
        else $error("core not held on contention");
endmodule
bind hpi_port hpi_port_props i_props (.clk_in(clk_in), .resetn_in(resetn_in),
    .wide_nonmux_mode_bit_in(wide_nonmux_mode_bit_in), .core_req_in(core_req_in),
    .core_addr_in(core_addr_in), .host_address_bus_in(host_address_bus_in),
    .dma_ack_in(dma_ack_in), .dma_req_out(dma_req_out), .dma_addr_out(dma_addr_out),
    .host_ready_output_out(host_ready_output_out), .host_int_n_out(host_int_n_out),
    .host_irq_core_out(host_irq_core_out), .host_data_bus_oe_out(host_data_bus_oe_out),
    .core_hold_out(core_hold_out));

// File: testbench/hpi_host_model.sv
// Host processor model that drives the host pins of the port.
`timescale 1ns/1ps
module hpi_host_model (
    // Clock, mode and answers from the port.
    input  wire        clk_in,
    input  wire        wide_in,
    input  wire        rdy_in,
    input  wire [7:0]  bq_in,
    input  wire [15:0] wq_in,
    // Host pins.
    output reg         cs_n_out = 1'b1,
    output reg         ds_n_out = 1'b1,
    output reg  [1:0]  typ_out = 2'h3,
    output reg         rw_out = 1'b1,
    output reg         bsel_out = 1'b0,
    output reg  [7:0]  bdat_out = 8'h00,
    output reg  [15:0] addr_out = 16'h0000,
    output reg  [15:0] wdat_out = 16'h0000
);
    task automatic xfer(input [1:0] t, input r, input b, input [15:0] a, input [15:0] d,
                        output [15:0] q);
        integer n;
        begin
            typ_out = t;
            rw_out = r;
            bsel_out = b;
            addr_out = a;
            wdat_out = d;
            bdat_out = d[7:0];
            cs_n_out = 1'b0;
            ds_n_out = 1'b0;
            repeat (2) @(posedge clk_in) #1;
            for (n = 0; n < 60 && rdy_in !== 1'b1; n = n + 1) @(posedge clk_in) #1;
            q = wide_in ? wq_in : {8'h00, bq_in};
            cs_n_out = 1'b1;
            ds_n_out = 1'b1;
            repeat (2) @(posedge clk_in) #1;
            for (n = 0; n < 60 && rdy_in !== 1'b1; n = n + 1) @(posedge clk_in) #1;
            // Released buses show the inverse so stale values never match.
            addr_out = ~a;
            wdat_out = ~d;
            bdat_out = ~d[7:0];
        end
    endtask
endmodule

// File: testbench/test_host_port_interface.sv
// Bench for the host port: wide and byte-wide accesses against a DMA memory.
`timescale 1ns/1ps
module test_host_port_interface;
    typedef struct packed {logic r; logic [15:0] a; logic [15:0] d;} hpi_row_t;
    hpi_row_t rows [0:4] = '{'{1'b0, 16'h0012, 16'ha55a}, '{1'b0, 16'hff34, 16'h1234},
        '{1'b1, 16'h0012, 16'ha55a}, '{1'b1, 16'hff34, 16'h1234}, '{1'b0, 16'h0012, 16'h0f0f}};
    logic        clk_in = 1'b0, resetn_in = 1'b0, wide = 1'b1, idle_level_one = 1'b0, idle_level_two = 1'b0;
    logic        emu = 1'b0, cirq = 1'b0, cack = 1'b0, clash = 1'b0, core_req = 1'b0;
    logic        dma_ack = 1'b0, cs_n, ds_n, rw, bsel, ready, int_n, irq_core, dma_req, dma_wr;
    logic        core_hold, clk_en;
    logic [7:0]  gpio_in;
    logic [1:0]  typ;
    logic [7:0]  bdat, bq;
    logic [15:0] addr, wdat, wq, dma_addr, dma_wdata, q, dma_rdata = 16'h0000;
    logic [15:0] core_addr = 16'h0000;
    logic [15:0] mem [0:255];
    integer      fail_count = 0, n_compared = 0, cyc = 0, lat = 0, wait_cnt = 0, i;
    always #20 clk_in = ~clk_in;
    hpi_port i_dut (.clk_in(clk_in), .resetn_in(resetn_in), .wide_nonmux_mode_bit_in(wide),
        .idle_level_one_in(idle_level_one), .idle_level_two_in(idle_level_two), .emu_stop_in(emu),
        .core_irq_host_in(cirq), .core_irq_ack_in(cack), .host_irq_core_out(irq_core),
        .access_clk_en_out(clk_en), .host_chip_select_n_in(cs_n), .host_data_strobe_one_n_in(ds_n),
        .host_data_strobe_two_n_in(1'b1), .host_read_write_in(rw), .byte_half_select_in(bsel),
        .access_type_select_in(typ), .host_ready_output_out(ready), .host_int_n_out(int_n),
        .host_data_bus_in(bdat), .host_data_bus_out(bq), .host_data_bus_oe_out(),
        .gpio_out_value_in(8'h00), .gpio_dir_in(8'h00), .gpio_in_value_out(gpio_in),
        .host_address_bus_in(addr), .wide_data_in(wdat), .wide_data_out(wq), .wide_data_oe_out(),
        .dma_req_out(dma_req), .dma_write_out(dma_wr), .dma_addr_out(dma_addr),
        .dma_wdata_out(dma_wdata), .dma_ack_in(dma_ack), .dma_rdata_in(dma_rdata),
        .core_req_in(core_req), .core_addr_in(core_addr), .core_hold_out(core_hold));
    hpi_host_model i_host (.clk_in(clk_in), .wide_in(wide), .rdy_in(ready), .bq_in(bq),
        .wq_in(wq), .cs_n_out(cs_n), .ds_n_out(ds_n), .typ_out(typ), .rw_out(rw),
        .bsel_out(bsel), .bdat_out(bdat), .addr_out(addr), .wdat_out(wdat));
    // On-chip memory behind the DMA bus; answers after lat wait cycles.
    always @(posedge clk_in) begin
        dma_ack <= 1'b0;
        dma_rdata <= ~dma_rdata;
        core_req <= clash & dma_req;
        core_addr <= dma_addr;
        if (dma_req && !dma_ack) begin
            wait_cnt <= (wait_cnt == lat) ? 0 : wait_cnt + 1;
            if (wait_cnt == lat) begin
                dma_ack <= 1'b1;
                dma_rdata <= mem[dma_addr[7:0]];
                if (dma_wr) mem[dma_addr[7:0]] <= dma_wdata;
            end
        end
    end
    task chk(input string nm, input [15:0] e, input [15:0] g);
        begin
            n_compared = n_compared + 1;
            if (g !== e) begin
                fail_count = fail_count + 1;
                $display("MISMATCH %s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task bword(input [1:0] t, input [15:0] w);
        begin
            i_host.xfer(t, 1'b0, 1'b0, 16'h0000, {8'h00, w[15:8]}, q);
            i_host.xfer(t, 1'b0, 1'b1, 16'h0000, {8'h00, w[7:0]}, q);
        end
    endtask
    task results;
        begin
            $display("compared %0d mismatches %0d", n_compared, fail_count);
            if (fail_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
            else $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count = fail_count + 1;
            results;
        end
    end
    initial begin
        repeat (10) @(posedge clk_in);
        #1 resetn_in = 1'b1;
        chk("reset state", 16'h0006, {13'h0000, ready, int_n, dma_req});
        for (i = 0; i < 5; i = i + 1) begin
            lat = i;
            i_host.xfer(2'h3, rows[i].r, 1'b0, rows[i].a, rows[i].d, q);
            if (rows[i].r) chk("wide read", rows[i].d, q);
        end
        cirq = 1'b1;
        @(posedge clk_in) #1 cirq = 1'b0;
        repeat (2) @(posedge clk_in) #1;
        chk("wide host irq", 16'h0001, {15'h0000, int_n});
        chk("gpio input", 16'h00f0, {8'h00, gpio_in});
        {idle_level_one, idle_level_two, emu, clash} = 4'hf;
        i_host.xfer(2'h3, 1'b1, 1'b0, 16'h0012, 16'h0000, q);
        chk("idle read", 16'h0f0f, q);
        chk("idle clocks off", 16'h0000, {15'h0000, clk_en});
        {idle_level_one, idle_level_two, emu, clash} = 4'h0;
        wide = 1'b0;
        lat = 1;
        bword(2'h0, 16'h0002);
        chk("irq to core", 16'h0001, {15'h0000, irq_core});
        @(posedge clk_in) #1 cack = 1'b1;
        @(posedge clk_in) #1 cack = 1'b0;
        cirq = 1'b1;
        @(posedge clk_in) #1 cirq = 1'b0;
        repeat (2) @(posedge clk_in) #1;
        chk("irq clear and host irq", 16'h0000, {14'h0000, irq_core, int_n});
        bword(2'h2, 16'h0040);
        bword(2'h1, 16'hbeef);
        bword(2'h1, 16'hcafe);
        chk("byte word", 16'hbeef, mem[8'h40]);
        chk("next word", 16'hcafe, mem[8'h41]);
        results;
    end
endmodule
